//--- logic/bzp_defs.svh
// constants for the buzzer and frequency-output pin sharing block
// Notes on behaviour
// - with the buzzer option on, the primary line, and with tone plus inverse the secondary, shows the tone instead of its latch when outputs.
// - a line set as input keeps plain input behaviour whatever option is chosen.
// - with tone plus inverse chosen, only the primary line's latch gates both tone outputs.
// - primary output drives tone when its latch is 1 and low when 0; secondary drives the inverse.
// - primary input and secondary output makes the secondary a plain port driving its own latch.
// - a static per-device option picks plain port or frequency output for the frequency line.
// - frequency option on and line an output drives it from the counter overflow signal.
// - the frequency output is gated only by its own latch: shown when 1, pad low when 0.
// - the frequency output toggles once per overflow, giving half the overflow rate.
// - with the counter stopped the pad is low whatever the latch value, 0 or 1.
// - running from preload N with latch 1 the output is input clock over 2 times (65536 - N).
// - the buzzer option has three choices: single tone line, tone plus inverse, or none.
// - a direction bit of 1 makes its line an input, 0 makes it an output.
`ifndef BZP_DEFS_SVH
`define BZP_DEFS_SVH

`define BZP_OFS_DATA 12'h000
`define BZP_OFS_DIR 12'h004
`define BZP_OFS_TCTL 12'h008
`define BZP_OFS_PRELOAD 12'h00C
`define BZP_OFS_COUNT 12'h010
`define BZP_OFS_PIN 12'h014
`define BZP_OFS_STAT 12'h018
`define BZP_OFS_OPT 12'h01C

`define BZP_RST_DATA 8'hFF
`define BZP_RST_DIR 8'hFF
`define BZP_RST_PRELOAD 16'h0000

`define BZP_TCTL_RUN 0
`define BZP_STAT_OVF 0
`define BZP_STAT_TONE 1
`define BZP_STAT_PFD 2

`define BZP_LINE_PRI 0
`define BZP_LINE_SEC 1
`define BZP_LINE_FREQ 7

`define BZP_CNT_W 16
`define BZP_FS_DIV 2
`define BZP_T1_DIV 1

`endif

//--- logic/bzp_pkg.sv
// types for the buzzer and frequency-output pin sharing block
package bzp_pkg;

    typedef enum logic [1:0] {
        BZP_BUZ_NONE,
        BZP_BUZ_SINGLE,
        BZP_BUZ_BOTH
    } bzp_buz_mode_type;

    typedef enum logic [1:0] {
        BZP_DIV2,
        BZP_DIV4,
        BZP_DIV8,
        BZP_DIV16
    } bzp_buz_div_type;

endpackage : bzp_pkg

//--- logic/bzp_tone_div.sv
// tone generator: fs enable divider followed by a selectable binary stage
`timescale 1ns/10ps
module bzp_tone_div #(
    parameter int FS_DIV = 2,
    parameter int SEL = 0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // tone
    output logic tone
);
    localparam int PW = (FS_DIV > 1) ? $clog2(FS_DIV) : 1;

    logic [PW-1:0] pre_q;
    logic [3:0] stage_q;
    logic fs_tick;

    generate
        if (FS_DIV < 1 || SEL < 0 || SEL > 3)
        begin : g_bad
            $error("bzp_tone_div: FS_DIV must be >= 1 and SEL 0..3");
        end
    endgenerate

    assign fs_tick = (pre_q == PW'(FS_DIV - 1));
    assign tone = stage_q[SEL];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_q <= '0;
            stage_q <= 4'h0;
        end
        else
        begin
            pre_q <= fs_tick ? '0 : pre_q + 1'b1;
            if (fs_tick)
            begin
                stage_q <= stage_q + 4'h1;
            end
        end
    end
endmodule : bzp_tone_div

//--- logic/bzp_ovf_counter.sv
// reloading up counter with prescaler and one-cycle overflow pulse
`timescale 1ns/10ps
module bzp_ovf_counter #(
    parameter int W = 16,
    parameter int DIV = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic [W-1:0] preload,
    // status
    output logic [W-1:0] count,
    output logic ovf
);
    localparam int PW = (DIV > 1) ? $clog2(DIV) : 1;

    logic [PW-1:0] pre_q;
    logic [W-1:0] count_q;
    logic ovf_q;
    logic tick;
    logic full;

    generate
        if (W < 2 || DIV < 1)
        begin : g_bad
            $error("bzp_ovf_counter: W must be >= 2 and DIV >= 1");
        end
    endgenerate

    assign tick = run && (pre_q == PW'(DIV - 1));
    assign full = &count_q;
    assign count = count_q;
    assign ovf = ovf_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_q <= '0;
            count_q <= '0;
            ovf_q <= 1'b0;
        end
        else
        begin
            // prescaler restarts on each run so the first period is whole
            pre_q <= (!run || tick) ? '0 : pre_q + 1'b1;
            ovf_q <= tick && full;
            if (load)
            begin
                count_q <= load_val;
            end
            else if (tick)
            begin
                count_q <= full ? preload : count_q + 1'b1;
            end
        end
    end
endmodule : bzp_ovf_counter

//--- logic/bzp_pin_mux.sv
// port A pin sharing with tone pair, frequency output and APB registers
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "bzp_defs.svh"
module bzp_pin_mux #(
    parameter bzp_pkg::bzp_buz_mode_type BUZ_MODE = bzp_pkg::BZP_BUZ_BOTH,
    parameter bzp_pkg::bzp_buz_div_type BUZ_DIV = bzp_pkg::BZP_DIV2,
    parameter bit PFD_EN = 1'b1,
    parameter int FS_DIV = `BZP_FS_DIV,
    parameter int T1_DIV = `BZP_T1_DIV
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port A pads
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe
);
    localparam int W = `BZP_CNT_W;

    // register state
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic [7:0] dir_q;
    logic [7:0] dir_d;
    logic run_q;
    logic run_d;
    logic [W-1:0] preload_q;
    logic [W-1:0] preload_d;
    logic [7:0] pin_q;
    logic ovf_flag_q;
    logic ovf_flag_d;
    logic pfd_q;
    logic pfd_d;
    logic [31:0] prdata_q;
    logic [31:0] rdata;
    logic [7:0] pa_out_q;
    logic [7:0] pa_out_d;
    logic [7:0] pa_oe_q;

    // decode
    logic access;
    logic wr_en;
    logic rd_setup;
    logic sel_data;
    logic sel_dir;
    logic sel_tctl;
    logic sel_preload;
    logic sel_count;
    logic sel_pin;
    logic sel_stat;
    logic sel_opt;
    logic addr_hit;
    logic ovf_clr;
    logic cnt_load;

    // sources
    logic tone;
    logic ovf;
    logic [W-1:0] count;
    logic buz_on;
    logic buz_both;
    logic line_pri;
    logic line_sec;
    logic line_freq;

    generate
        if (FS_DIV < 1 || T1_DIV < 1)
        begin : g_bad
            $error("bzp_pin_mux: FS_DIV and T1_DIV must be >= 1");
        end
    endgenerate

    // latch gating: show the source when the latch is 1, low otherwise
    function automatic logic gate_out(input logic latch, input logic src);
        gate_out = latch & src;
    endfunction : gate_out

    function automatic logic [7:0] put_byte(input logic [7:0] old, input logic [7:0] wd,
                                            input logic en);
        put_byte = en ? wd : old;
    endfunction : put_byte

    assign access = psel && penable;
    assign wr_en = access && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    assign sel_data = (paddr == `BZP_OFS_DATA);
    assign sel_dir = (paddr == `BZP_OFS_DIR);
    assign sel_tctl = (paddr == `BZP_OFS_TCTL);
    assign sel_preload = (paddr == `BZP_OFS_PRELOAD);
    assign sel_count = (paddr == `BZP_OFS_COUNT);
    assign sel_pin = (paddr == `BZP_OFS_PIN);
    assign sel_stat = (paddr == `BZP_OFS_STAT);
    assign sel_opt = (paddr == `BZP_OFS_OPT);
    assign addr_hit = sel_data | sel_dir | sel_tctl | sel_preload | sel_count
                    | sel_pin | sel_stat | sel_opt;

    // zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !addr_hit;
    assign prdata = prdata_q;

    assign data_d = (wr_en && sel_data) ? put_byte(data_q, pwdata[7:0], pstrb[0]) : data_q;
    assign dir_d = (wr_en && sel_dir) ? put_byte(dir_q, pwdata[7:0], pstrb[0]) : dir_q;
    assign run_d = (wr_en && sel_tctl && pstrb[0]) ? pwdata[`BZP_TCTL_RUN] : run_q;
    assign preload_d = (wr_en && sel_preload)
                     ? {put_byte(preload_q[15:8], pwdata[15:8], pstrb[1]),
                        put_byte(preload_q[7:0], pwdata[7:0], pstrb[0])}
                     : preload_q;

    // a stopped counter takes the preload at once; a running one at overflow
    assign cnt_load = wr_en && sel_preload && !run_q;

    // overflow set wins over a write-one clear in the same cycle
    assign ovf_clr = wr_en && sel_stat && pstrb[0] && pwdata[`BZP_STAT_OVF];
    assign ovf_flag_d = ovf | (ovf_flag_q & !ovf_clr);

    assign pfd_d = (!run_q || !data_q[`BZP_LINE_FREQ]) ? 1'b0
                 : (ovf ? !pfd_q : pfd_q);

    assign buz_on = (BUZ_MODE != bzp_pkg::BZP_BUZ_NONE);
    assign buz_both = (BUZ_MODE == bzp_pkg::BZP_BUZ_BOTH);

    // the primary latch alone gates both tone lines
    assign line_pri = buz_on ? gate_out(data_q[`BZP_LINE_PRI], tone)
                    : data_q[`BZP_LINE_PRI];
    // inverse tone only while the primary line is an output too
    assign line_sec = (buz_both && !dir_q[`BZP_LINE_PRI])
                    ? gate_out(data_q[`BZP_LINE_PRI], !tone)
                    : data_q[`BZP_LINE_SEC];
    assign line_freq = PFD_EN ? gate_out(data_q[`BZP_LINE_FREQ], pfd_q)
                     : data_q[`BZP_LINE_FREQ];

    assign pa_out_d = {line_freq, data_q[6:2], line_sec, line_pri};

    always_comb
    begin
        rdata = 32'h0000_0000;
        if (sel_data)
        begin
            rdata[7:0] = data_q;
        end
        if (sel_dir)
        begin
            rdata[7:0] = dir_q;
        end
        if (sel_tctl)
        begin
            rdata[`BZP_TCTL_RUN] = run_q;
        end
        if (sel_preload)
        begin
            rdata[W-1:0] = preload_q;
        end
        if (sel_count)
        begin
            rdata[W-1:0] = count;
        end
        if (sel_pin)
        begin
            rdata[7:0] = pin_q;
        end
        if (sel_stat)
        begin
            rdata[`BZP_STAT_OVF] = ovf_flag_q;
            rdata[`BZP_STAT_TONE] = tone;
            rdata[`BZP_STAT_PFD] = pfd_q;
        end
        if (sel_opt)
        begin
            rdata[4:0] = {PFD_EN, BUZ_DIV, BUZ_MODE};
        end
    end

    bzp_tone_div #(
        .FS_DIV(FS_DIV),
        .SEL(int'(BUZ_DIV))
    ) u_tone (
        .pclk(pclk),
        .presetn(presetn),
        .tone(tone)
    );

    bzp_ovf_counter #(
        .W(W),
        .DIV(T1_DIV)
    ) u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_q),
        .load(cnt_load),
        .load_val(preload_d),
        .preload(preload_q),
        .count(count),
        .ovf(ovf)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_q <= `BZP_RST_DATA;
            dir_q <= `BZP_RST_DIR;
            run_q <= 1'b0;
            preload_q <= `BZP_RST_PRELOAD;
            ovf_flag_q <= 1'b0;
            pfd_q <= 1'b0;
        end
        else
        begin
            data_q <= data_d;
            dir_q <= dir_d;
            run_q <= run_d;
            preload_q <= preload_d;
            ovf_flag_q <= ovf_flag_d;
            pfd_q <= pfd_d;
        end
    end

    // pads and read data are registered; pready is tied high and pslverr is decoded straight from the bus
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pa_out_q <= 8'h00;
            pa_oe_q <= 8'h00;
            pin_q <= 8'h00;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pa_out_q <= pa_out_d;
            pa_oe_q <= ~dir_q;
            pin_q <= pa_in;
            if (rd_setup)
            begin
                prdata_q <= rdata;
            end
        end
    end

    // an input line never drives, so the value behind it is hidden
    assign pa_out = pa_out_q & pa_oe_q;
    assign pa_oe = pa_oe_q;
endmodule : bzp_pin_mux

//--- sim/bzp_pin_mux_monitor.sv
// port-level assertion checker for the pin sharing block
`timescale 1ns/10ps
module bzp_pin_mux_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pads
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_access;
        psel && penable;
    endsequence
    sequence s_dir_write;
        s_access ##0 (pwrite && pstrb[0] && paddr == 12'h004);
    endsequence

    a_no_drive_in:
        assert property ((pa_out & ~pa_oe) == 8'h00) else $error("input line driven");
    a_dir_sets_oe:
        assert property (s_dir_write |-> ##2 pa_oe == ~$past(pwdata[7:0], 2))
        else $error("oe not following direction write");
    a_tone_pair_excl:
        assert property (pa_oe[1:0] == 2'b11 |-> !(pa_out[0] && pa_out[1]))
        else $error("tone pair both high");
    a_unmapped_zero:
        assert property (s_access ##0 (!pwrite && paddr > 12'h01C) |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero:
        assert property (s_access ##0 (!pwrite && paddr != 12'h00C && paddr != 12'h010)
            |-> prdata[31:8] == 24'h0) else $error("unused read bits set");
    a_err_decode:
        assert property (s_access |-> pslverr == (paddr > 12'h01C || paddr[1:0] != 2'b00))
        else $error("bad error flag");
    a_err_idle:
        assert property (!(psel && penable) |-> !pslverr) else $error("error outside access");
    a_ready_high:
        assert property (pready) else $error("ready low");
endmodule : bzp_pin_mux_monitor

//--- sim/bzp_pad_load.sv
// external buzzer and frequency load on the port pads
`timescale 1ns/10ps
module bzp_pad_load (
    // pads from the block
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe,
    // level the load puts on released lines
    input wire logic [7:0] ext_level,
    // sensed levels
    output logic [7:0] pa_in,
    output logic tone_diff
);
    // released lines take the load level, never a stale drive
    assign pa_in = (pa_out & pa_oe) | (ext_level & ~pa_oe);
    // piezo only sounds on a true differential pair
    assign tone_diff = pa_oe[0] & pa_oe[1] & (pa_out[0] ^ pa_out[1]);
endmodule : bzp_pad_load

//--- sim/bzp_pin_mux_bench.sv
// self-checking bench for the pin sharing block
`timescale 1ns/10ps
`include "bzp_defs.svh"
module bzp_pin_mux_bench;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pa_in;
    logic [7:0] pa_out;
    logic [7:0] pa_oe;
    logic [7:0] ext_level;
    logic tone_diff;
    logic [7:0] pa_out_b;
    logic [7:0] pa_oe_b;
    logic [31:0] rdat;
    logic err;
    logic last;
    int mismatches = 0;
    int checked = 0;
    int cyc = 0;
    int i;
    int t;
    int r[$];

    bzp_pin_mux i_bzp_pin_mux (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .pa_in, .pa_out, .pa_oe);
    bzp_pad_load i_bzp_pad_load (.pa_out, .pa_oe, .ext_level, .pa_in, .tone_diff);
    // second option set on the same bus: single tone line, plain frequency line
    bzp_pin_mux #(
        .BUZ_MODE(bzp_pkg::BZP_BUZ_SINGLE),
        .PFD_EN(1'b0)
    ) i_bzp_pin_mux_single (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata(), .pready(), .pslverr(), .pa_in, .pa_out(pa_out_b), .pa_oe(pa_oe_b));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            complete_run();
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends a hung transfer
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // pads trail the registers by one edge
    task settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    task complete_run;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        ext_level = 8'hA5;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        chk("oe after reset", 8'h00, pa_oe);
        apb(0, `BZP_OFS_DIR, 0);
        chk("dir reset", 32'hFF, rdat);
        apb(0, `BZP_OFS_DATA, 0);
        chk("data reset", 32'hFF, rdat);
        apb(0, `BZP_OFS_PIN, 0);
        chk("input levels", 32'hA5, rdat);
        apb(0, `BZP_OFS_OPT, 0);
        chk("options", 32'h12, rdat);
        apb(0, 12'h020, 0);
        chk("unmapped error", 1, err);
        apb(1, `BZP_OFS_DATA, 0);
        apb(1, `BZP_OFS_DIR, 0);
        settle();
        chk("all outputs", 8'hFF, pa_oe);
        chk("latches low", 8'h00, pa_out);
        // secondary latch 0 must not stop the inverse tone
        apb(1, `BZP_OFS_DATA, 32'h01);
        settle();
        t = 0;
        last = pa_out[0];
        for (i = 0; i < 64; i++)
        begin
            @(posedge pclk);
            #1;
            chk("tone pair", 1, tone_diff);
            chk("single secondary low", 0, pa_out_b[1]);
            if (pa_out[0] !== last)
                t++;
            last = pa_out[0];
        end
        chk("tone toggles", 1, t > 0);
        apb(1, `BZP_OFS_DATA, 32'h02);
        settle();
        chk("pair gated", 2'b00, pa_out[1:0]);
        chk("single secondary high", 1, pa_out_b[1]);
        apb(1, `BZP_OFS_DIR, 32'h01);
        settle();
        chk("primary released", 0, pa_oe[0]);
        chk("secondary latch 1", 1, pa_out[1]);
        apb(1, `BZP_OFS_DATA, 0);
        settle();
        chk("secondary latch 0", 0, pa_out[1]);
        // preload FFF0 gives a period of 2 x 16 cycles
        apb(1, `BZP_OFS_PRELOAD, 32'hFFF0);
        apb(1, `BZP_OFS_DATA, 32'h80);
        apb(1, `BZP_OFS_TCTL, 32'h1);
        last = pa_out[7];
        for (i = 0; i < 200; i++)
        begin
            @(posedge pclk);
            #1;
            if (pa_out[7] === 1'b1 && last === 1'b0)
                r.push_back(i);
            last = pa_out[7];
        end
        if (r.size() < 3)
            chk("freq edges", 3, r.size());
        else
            chk("freq period", 32, r[2] - r[1]);
        chk("plain freq line", 1, pa_out_b[7]);
        apb(0, `BZP_OFS_STAT, 0);
        chk("overflow flag", 1, rdat[`BZP_STAT_OVF]);
        apb(1, `BZP_OFS_DATA, 0);
        repeat (40) @(posedge pclk);
        #1;
        chk("freq gated", 0, pa_out[7]);
        apb(1, `BZP_OFS_TCTL, 0);
        settle();
        chk("stopped low", 0, pa_out[7]);
        // latch set while stopped must not wake the toggle
        apb(1, `BZP_OFS_DATA, 32'h80);
        apb(0, `BZP_OFS_STAT, 0);
        chk("toggle held", 0, rdat[`BZP_STAT_PFD]);
        complete_run();
    end
endmodule : bzp_pin_mux_bench

bind bzp_pin_mux bzp_pin_mux_monitor i_bzp_pin_mux_monitor (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pa_out, .pa_oe);
